// ===== logic/dfifo_map.svh
// constants for the data fifo and its port steering
`ifndef DFIFO_MAP_SVH
`define DFIFO_MAP_SVH

`define DFIFO_QUADS       32
`define QWORD_W           64
`define BYTE_W            8
`define DFIFO_BYTE_LANES  8
`define BYTE_OFF_W        3
`define LAST_BYTE_OFF     3'h7
`define ZERO_BYTE_OFF     3'h0
`define HOST_PORT_OFF     3'h0
`define HOST_BLOCK_UPPER  3'h4
`define HOST_COUNT_W      24
`define HOST_COUNT_ONE    24'h000001
`define HOST_COUNT_ZERO   24'h000000
`define PCI_OFF_W         2
`define WR_LANE_ONE       8'h01

`endif

// ===== logic/dfifo_pkg.sv
// types shared by the data fifo modules
package dfifo_pkg;

   // fifo port that reads or writes
   typedef enum logic [1:0] {
      PORT_SEQ  = 2'h0,
      PORT_HOST = 2'h1,
      PORT_SCSI = 2'h2
   } port_sel_t;

endpackage

// ===== logic/dfifo_mem_if.sv
// carrier between the fifo control and its quad-word storage
`timescale 1ns/1ps
`include "dfifo_map.svh"

interface dfifo_mem_if #(
   parameter int AW = 5
);
   logic                           wr_en;
   logic [AW-1:0]                  wr_addr;
   logic [`DFIFO_BYTE_LANES-1:0]   wr_be;
   logic [`QWORD_W-1:0]            wr_data;
   logic                           rd_en;
   logic [AW-1:0]                  rd_addr;
   logic [`QWORD_W-1:0]            rd_q;

   modport ctrl (
      output wr_en,
      output wr_addr,
      output wr_be,
      output wr_data,
      output rd_en,
      output rd_addr,
      input  rd_q
   );

   modport store (
      input  wr_en,
      input  wr_addr,
      input  wr_be,
      input  wr_data,
      input  rd_en,
      input  rd_addr,
      output rd_q
   );
endinterface

// ===== logic/dfifo_mem.sv
// quad-word fifo storage with byte write lanes and registered read
`timescale 1ns/1ps
`include "dfifo_map.svh"

module dfifo_mem #(
   parameter int DEPTH = `DFIFO_QUADS,
   parameter int AW    = $clog2(DEPTH)
) (
   input wire logic   clock,
   dfifo_mem_if.store mem
);
   logic [`QWORD_W-1:0] store_r [DEPTH];
   logic [`QWORD_W-1:0] rd_q_r;

   // storage has no reset; contents are defined only once written
   always_ff @(posedge clock) begin
      for (int i = 0; i < `DFIFO_BYTE_LANES; i++) begin
         if (mem.wr_en && mem.wr_be[i]) begin
            store_r[mem.wr_addr][i*`BYTE_W +: `BYTE_W] <=
               mem.wr_data[i*`BYTE_W +: `BYTE_W];
         end
      end
      if (mem.rd_en) begin
         rd_q_r <= store_r[mem.rd_addr];
      end
   end

   assign mem.rd_q = rd_q_r;
endmodule

// ===== logic/dfifo_steer.sv
// data fifo with host, scsi and sequencer port steering
// Function
// R1: reads allowed any time; only the single selected writer may write.
// R2: two writers enabled together raise the diagnostic break flag.
// R3: only the scsi, host and sequencer i/o ports reach the fifo.
// R4: read and write pointers address quad-words; byte offsets held apart.
// R5: pointer reset zeroes both quad pointers and loads byte offsets.
// R6: write pointer steps on accepted writes, read pointer on any read.
// R7: write pointer may be reloaded, byte offset kept; writes then consecutive.
// R8: read pointer may be reloaded, byte offset kept; reads then consecutive.
// R9: outbound dma: fill via i/o port, enable host read; done flags end.
// R10: inbound dma: host fills fifo, done flags end, then i/o port reads.
// R11: direction and two dma enables choose the reading and writing port.
// R12: seq offset is address bits, scsi clears bit zero, host is zero.
// R13: pci offset is low two bits, host block 4 or 0, scsi bit zero.
// R14: offsets come from low host address at reset, no sequencer help.
// R15: byte offsets step per byte and carry into the quad pointer.
`timescale 1ns/1ps
`include "dfifo_map.svh"

module dfifo_steer #(
   parameter int DEPTH = `DFIFO_QUADS,
   parameter int AW    = $clog2(DEPTH),
   parameter int CW    = `HOST_COUNT_W
) (
   input  wire logic                   clock,
   input  wire logic                   srst,
   input  wire logic                   direction,
   input  wire logic                   host_dma_enable,
   input  wire logic                   scsi_dma_enable,
   input  wire logic                   buffer_pointer_reset,
   input  wire logic [`BYTE_OFF_W-1:0] low_host_address,
   input  wire logic [CW-1:0]          host_byte_count,
   input  wire logic                   wr_pointer_load,
   input  wire logic [AW-1:0]          wr_pointer,
   input  wire logic                   rd_pointer_load,
   input  wire logic [AW-1:0]          rd_pointer,
   input  wire logic                   seq_wr,
   input  wire logic [`BYTE_W-1:0]     seq_wdata,
   input  wire logic                   seq_rd,
   input  wire logic                   host_wr,
   input  wire logic [`BYTE_W-1:0]     host_wdata,
   input  wire logic                   host_rd,
   input  wire logic                   scsi_wr,
   input  wire logic [`BYTE_W-1:0]     scsi_wdata,
   input  wire logic                   scsi_rd,
   input  wire logic                   diag_clear,
   output logic [`BYTE_W-1:0]          rd_data,
   output logic                        rd_valid,
   output logic [AW-1:0]               fifo_wr_quad_ptr,
   output logic [AW-1:0]               fifo_rd_quad_ptr,
   output logic [`BYTE_OFF_W-1:0]      wr_byte_offset,
   output logic [`BYTE_OFF_W-1:0]      rd_byte_offset,
   output dfifo_pkg::port_sel_t        read_port,
   output dfifo_pkg::port_sel_t        write_port,
   output logic                        host_transfer_done,
   output logic                        diag_break_interrupt,
   output logic [`PCI_OFF_W-1:0]       pci_byte_offset,
   output logic [`BYTE_OFF_W-1:0]      host_block_offset,
   output logic                        scsi_block_offset
);

   // ==========================================================
   // port selection and offset decode
   function automatic dfifo_pkg::port_sel_t rd_src_f(
      input logic d, input logic h, input logic s);
      dfifo_pkg::port_sel_t p;
      p = dfifo_pkg::PORT_SEQ;
      unique case ({d, h, s})
         3'h3:    p = dfifo_pkg::PORT_HOST;
         3'h1:    p = dfifo_pkg::PORT_SEQ;
         3'h2:    p = dfifo_pkg::PORT_HOST;
         3'h0:    p = dfifo_pkg::PORT_SEQ;
         3'h4:    p = dfifo_pkg::PORT_SEQ;
         3'h7:    p = dfifo_pkg::PORT_SCSI;
         3'h5:    p = dfifo_pkg::PORT_SCSI;
         3'h6:    p = dfifo_pkg::PORT_SEQ;
      endcase
      return p;
   endfunction

   function automatic dfifo_pkg::port_sel_t wr_src_f(
      input logic d, input logic h, input logic s);
      dfifo_pkg::port_sel_t p;
      p = dfifo_pkg::PORT_SEQ;
      unique case ({d, h, s})
         3'h3:    p = dfifo_pkg::PORT_SCSI;
         3'h1:    p = dfifo_pkg::PORT_SCSI;
         3'h2:    p = dfifo_pkg::PORT_SEQ;
         3'h0:    p = dfifo_pkg::PORT_SEQ;
         3'h4:    p = dfifo_pkg::PORT_SEQ;
         3'h7:    p = dfifo_pkg::PORT_HOST;
         3'h5:    p = dfifo_pkg::PORT_SEQ;
         3'h6:    p = dfifo_pkg::PORT_HOST;
      endcase
      return p;
   endfunction

   function automatic logic [`BYTE_OFF_W-1:0] port_off_f(
      input dfifo_pkg::port_sel_t p, input logic [`BYTE_OFF_W-1:0] a);
      logic [`BYTE_OFF_W-1:0] o;
      o = `ZERO_BYTE_OFF;
      unique case (p)
         dfifo_pkg::PORT_SEQ:  o = a;                            // [R12]
         dfifo_pkg::PORT_SCSI: o = {a[`BYTE_OFF_W-1:1], 1'b0};   // [R12]
         dfifo_pkg::PORT_HOST: o = `HOST_PORT_OFF;               // [R12]
         default:              o = `ZERO_BYTE_OFF;
      endcase
      return o;
   endfunction

   function automatic logic [AW-1:0] quad_step_f(
      input logic [AW-1:0] q, input logic [`BYTE_OFF_W-1:0] off);
      return (off == `LAST_BYTE_OFF) ? AW'(q + 1'b1) : q;      // [R15]
   endfunction

   dfifo_pkg::port_sel_t rd_src;
   dfifo_pkg::port_sel_t wr_src;
   logic [2:0]           wr_vec;
   logic [2:0]           rd_vec;
   logic [2:0]           wr_sel_vec;
   logic                 wr_clash;
   logic                 wr_ok;
   logic                 rd_go;
   logic [`BYTE_W-1:0]   wr_byte;
   logic                 host_xfer;
   logic [`BYTE_OFF_W-1:0] wr_off_rst;
   logic [`BYTE_OFF_W-1:0] rd_off_rst;

   // only three ports exist; each has one strobe bit per vector
   assign rd_src = rd_src_f(direction, host_dma_enable,
                            scsi_dma_enable);                     // [R11]
   assign wr_src = wr_src_f(direction, host_dma_enable,
                            scsi_dma_enable);                     // [R11]
   assign wr_vec = {scsi_wr, host_wr, seq_wr};                    // [R3]
   assign rd_vec = {scsi_rd, host_rd, seq_rd};                    // [R3]
   assign wr_sel_vec = 3'h1 << wr_src;
   // a second write strobe or a strobe from an unselected port is a clash
   assign wr_clash = ($countones(wr_vec) > 1) ||
                     ((wr_vec & ~wr_sel_vec) != 3'h0);            // [R2]
   assign wr_ok = ((wr_vec & wr_sel_vec) != 3'h0) && !wr_clash;   // [R1]
   assign rd_go = (rd_vec != 3'h0);                               // [R1]
   assign wr_off_rst = port_off_f(wr_src, low_host_address);     // [R14]
   assign rd_off_rst = port_off_f(rd_src, low_host_address);     // [R14]
   assign host_xfer = (wr_ok && wr_src == dfifo_pkg::PORT_HOST) ||
                      (rd_go && rd_src == dfifo_pkg::PORT_HOST &&
                       host_rd);

   always_comb begin
      unique case (wr_src)
         dfifo_pkg::PORT_HOST: wr_byte = host_wdata;
         dfifo_pkg::PORT_SCSI: wr_byte = scsi_wdata;
         default:              wr_byte = seq_wdata;
      endcase
   end

   // ==========================================================
   // pointers
   logic [AW-1:0]          wr_q_r, wr_q_nxt;
   logic [AW-1:0]          rd_q_r, rd_q_nxt;
   logic [`BYTE_OFF_W-1:0] wr_off_r, wr_off_nxt;
   logic [`BYTE_OFF_W-1:0] rd_off_r, rd_off_nxt;

   always_comb begin
      wr_q_nxt   = wr_q_r;
      wr_off_nxt = wr_off_r;
      rd_q_nxt   = rd_q_r;
      rd_off_nxt = rd_off_r;
      if (buffer_pointer_reset) begin
         wr_q_nxt   = '0;                                         // [R5]
         rd_q_nxt   = '0;                                         // [R5]
         wr_off_nxt = wr_off_rst;                                 // [R5]
         rd_off_nxt = rd_off_rst;                                 // [R5]
      end else begin
         if (wr_pointer_load) begin
            wr_q_nxt = wr_pointer;                                // [R7]
         end else if (wr_ok) begin
            wr_q_nxt   = quad_step_f(wr_q_r, wr_off_r);           // [R6]
            wr_off_nxt = `BYTE_OFF_W'(wr_off_r + 1'b1);           // [R15]
         end
         if (rd_pointer_load) begin
            rd_q_nxt = rd_pointer;                                // [R8]
         end else if (rd_go) begin
            rd_q_nxt   = quad_step_f(rd_q_r, rd_off_r);           // [R6]
            rd_off_nxt = `BYTE_OFF_W'(rd_off_r + 1'b1);           // [R15]
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         wr_q_r   <= '0;
         rd_q_r   <= '0;
         wr_off_r <= `ZERO_BYTE_OFF;
         rd_off_r <= `ZERO_BYTE_OFF;
      end else begin
         wr_q_r   <= wr_q_nxt;
         rd_q_r   <= rd_q_nxt;
         wr_off_r <= wr_off_nxt;
         rd_off_r <= rd_off_nxt;
      end
   end

   // ==========================================================
   // storage: one byte lane per access, quad-word rows
   dfifo_mem_if #(.AW(AW)) mem_bus ();

   assign mem_bus.wr_en   = wr_ok && !buffer_pointer_reset && !wr_pointer_load;
   assign mem_bus.wr_addr = wr_q_r;                               // [R4]
   assign mem_bus.wr_be   = `WR_LANE_ONE << wr_off_r;             // [R4]
   assign mem_bus.wr_data = {`DFIFO_BYTE_LANES{wr_byte}};
   assign mem_bus.rd_en   = rd_go;
   assign mem_bus.rd_addr = rd_q_r;                               // [R4]

   dfifo_mem #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) dfifo_mem_inst (
      .clock (clock),
      .mem   (mem_bus.store)
   );

   // ==========================================================
   // read data path: two cycles from strobe to data
   logic                   rd_pend_r, rd_pend_nxt;
   logic [`BYTE_OFF_W-1:0] rd_lane_r, rd_lane_nxt;
   logic [`BYTE_W-1:0]     rd_data_r, rd_data_nxt;
   logic                   rd_valid_r, rd_valid_nxt;

   always_comb begin
      rd_pend_nxt  = rd_go;
      rd_lane_nxt  = rd_off_r;
      rd_valid_nxt = rd_pend_r;
      rd_data_nxt  = rd_data_r;
      if (rd_pend_r) begin
         rd_data_nxt = mem_bus.rd_q[rd_lane_r*`BYTE_W +: `BYTE_W];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rd_pend_r  <= 1'b0;
         rd_lane_r  <= `ZERO_BYTE_OFF;
         rd_data_r  <= '0;
         rd_valid_r <= 1'b0;
      end else begin
         rd_pend_r  <= rd_pend_nxt;
         rd_lane_r  <= rd_lane_nxt;
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   // ==========================================================
   // host dma count, done flag, diagnostic flag, offsets
   logic [CW-1:0]            host_byte_count_r, host_byte_count_nxt;
   logic                     done_r, done_nxt;
   logic                     diag_r, diag_nxt;
   logic [`PCI_OFF_W-1:0]    pci_off_r, pci_off_nxt;
   logic [`BYTE_OFF_W-1:0]   hblk_off_r, hblk_off_nxt;
   logic                     sblk_off_r, sblk_off_nxt;
   dfifo_pkg::port_sel_t     rd_port_r, wr_port_r;
   logic                     last_host;

   assign last_host = host_xfer && host_dma_enable &&
                      (host_byte_count_r == CW'(`HOST_COUNT_ONE));

   always_comb begin
      host_byte_count_nxt = host_byte_count_r;
      done_nxt = done_r;
      if (buffer_pointer_reset) begin
         host_byte_count_nxt = host_byte_count;
         done_nxt = 1'b0;
      end else if (host_xfer && host_dma_enable &&
                   host_byte_count_r != CW'(`HOST_COUNT_ZERO)) begin
         host_byte_count_nxt = CW'(host_byte_count_r - 1'b1);
      end
      // the last byte wins over a reset in the same cycle
      if (last_host) begin
         done_nxt = 1'b1;                                         // [R9] [R10]
      end
      diag_nxt = (diag_r && !diag_clear) || wr_clash;             // [R2]
      pci_off_nxt  = low_host_address[`PCI_OFF_W-1:0];            // [R13]
      hblk_off_nxt = low_host_address[`BYTE_OFF_W-1] ? `HOST_BLOCK_UPPER
                                         : `ZERO_BYTE_OFF;        // [R13]
      sblk_off_nxt = low_host_address[0];                         // [R13]
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         host_byte_count_r     <= '0;
         done_r     <= 1'b0;
         diag_r     <= 1'b0;
         pci_off_r  <= '0;
         hblk_off_r <= `ZERO_BYTE_OFF;
         sblk_off_r <= 1'b0;
         rd_port_r  <= dfifo_pkg::PORT_SEQ;
         wr_port_r  <= dfifo_pkg::PORT_SEQ;
      end else begin
         host_byte_count_r     <= host_byte_count_nxt;
         done_r     <= done_nxt;
         diag_r     <= diag_nxt;
         pci_off_r  <= pci_off_nxt;
         hblk_off_r <= hblk_off_nxt;
         sblk_off_r <= sblk_off_nxt;
         rd_port_r  <= rd_src;
         wr_port_r  <= wr_src;
      end
   end

   assign rd_data              = rd_data_r;
   assign rd_valid             = rd_valid_r;
   assign fifo_wr_quad_ptr     = wr_q_r;
   assign fifo_rd_quad_ptr     = rd_q_r;
   assign wr_byte_offset       = wr_off_r;
   assign rd_byte_offset       = rd_off_r;
   assign read_port            = rd_port_r;
   assign write_port           = wr_port_r;
   assign host_transfer_done   = done_r;
   assign diag_break_interrupt = diag_r;
   assign pci_byte_offset      = pci_off_r;
   assign host_block_offset    = hblk_off_r;
   assign scsi_block_offset    = sblk_off_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_reset_zero_ptrs: assert property ( // [R5]
      buffer_pointer_reset |=> wr_q_r == '0 && rd_q_r == '0)
      else $error("pointer reset left a quad pointer nonzero");
   a_reset_off_load: assert property ( // [R12]
      buffer_pointer_reset |=> wr_off_r == $past(wr_off_rst) &&
                               rd_off_r == $past(rd_off_rst))
      else $error("byte offsets not loaded from low address");
   a_clash_flags: assert property ( // [R2]
      $countones(wr_vec) > 1 |=>
      diag_r ##1 (diag_r || $past(diag_clear)))
      else $error("double writer did not raise diag flag");
   a_stray_hold: assert property ( // [R1]
      wr_clash && !buffer_pointer_reset && !wr_pointer_load |=>
      $stable(wr_q_r) && $stable(wr_off_r))
      else $error("clashing write moved the write pointer");
   a_wr_carry: assert property ( // [R15]
      wr_ok && !buffer_pointer_reset && !wr_pointer_load &&
      wr_off_r == `LAST_BYTE_OFF |=>
      wr_q_r == AW'($past(wr_q_r) + 1'b1) && wr_off_r == `ZERO_BYTE_OFF)
      else $error("write byte carry did not step quad pointer");
   a_wload_keep: assert property ( // [R7]
      wr_pointer_load && !buffer_pointer_reset |=>
      wr_q_r == $past(wr_pointer) && $stable(wr_off_r))
      else $error("write pointer load lost value or offset");
   a_rload_keep: assert property ( // [R8]
      rd_pointer_load && !buffer_pointer_reset |=>
      rd_q_r == $past(rd_pointer) && $stable(rd_off_r))
      else $error("read pointer load lost value or offset");
   a_read_latency: assert property ( // [R6]
      rd_go |-> ##2 rd_valid_r)
      else $error("read data not valid two cycles after strobe");
   a_dma_done: assert property ( // [R9]
      last_host |=> done_r ##1 (done_r || $past(buffer_pointer_reset)))
      else $error("done flag not set on last host byte");
   a_flow_select: assert property ( // [R11]
      direction && host_dma_enable && scsi_dma_enable |=>
      read_port == dfifo_pkg::PORT_SCSI && write_port == dfifo_pkg::PORT_HOST)
      else $error("flow table selection wrong");
   a_host_blk_off: assert property ( // [R13]
      ##1 host_block_offset == ($past(low_host_address[2]) ?
                                `HOST_BLOCK_UPPER : `ZERO_BYTE_OFF))
      else $error("host block offset wrong");

endmodule

// ===== dv/dma_peer.sv
// behavioural host dma port that feeds or drains the data fifo
`timescale 1ns/1ps

module dma_peer (
   input  wire logic       clock,
   input  wire logic       run,
   input  wire logic       to_fifo,
   input  wire logic       slow,
   input  wire logic [7:0] n_bytes,
   output logic            busy,
   output logic            host_wr,
   output logic            host_rd,
   output logic [7:0]      host_wdata
);
   logic [7:0] last;

   initial begin
      busy = 1'b0;
      host_wr = 1'b0;
      host_rd = 1'b0;
      last = 8'h5a;
      host_wdata = ~last;
      forever begin
         @(posedge clock);
         if (run) begin
            busy = 1'b1;
            @(negedge clock);
            for (int i = 0; i < n_bytes; i++) begin
               last = 8'ha0 + i[7:0];
               host_wdata = last;
               host_wr = to_fifo;
               host_rd = !to_fifo;
               @(negedge clock);
               if (slow) begin
                  // stall: strobes drop and the data bus stops holding
                  host_wr = 1'b0;
                  host_rd = 1'b0;
                  host_wdata = ~last;
                  @(negedge clock);
               end
            end
            host_wr = 1'b0;
            host_rd = 1'b0;
            host_wdata = ~last;
            busy = 1'b0;
         end
      end
   end
endmodule

// ===== dv/data_fifo_port_steering_bench.sv
// self-checking bench for the data fifo port steering block
`timescale 1ns/1ps

module data_fifo_port_steering_bench;
   localparam dfifo_pkg::port_sel_t SQ = dfifo_pkg::PORT_SEQ;
   localparam dfifo_pkg::port_sel_t HO = dfifo_pkg::PORT_HOST;
   localparam dfifo_pkg::port_sel_t SC = dfifo_pkg::PORT_SCSI;

   logic        clock, srst, direction, host_dma_enable, scsi_dma_enable;
   logic        buffer_pointer_reset, wr_pointer_load, rd_pointer_load;
   logic        seq_wr, seq_rd, host_wr, host_rd, scsi_wr, scsi_rd;
   logic        diag_clear, rd_valid, host_transfer_done;
   logic        diag_break_interrupt, scsi_block_offset;
   logic        peer_run, peer_to_fifo, peer_slow, peer_busy;
   logic [2:0]  low_host_address, wr_byte_offset, rd_byte_offset;
   logic [2:0]  host_block_offset;
   logic [1:0]  pci_byte_offset;
   logic [4:0]  wr_pointer, rd_pointer, fifo_wr_quad_ptr, fifo_rd_quad_ptr;
   logic [7:0]  seq_wdata, host_wdata, scsi_wdata, rd_data, peer_n;
   logic [23:0] host_byte_count;
   dfifo_pkg::port_sel_t read_port, write_port;
   logic [7:0]  rdq[$];
   int          n_fail = 0;
   int          samples_checked = 0;

   dfifo_steer dfifo_steer_inst (
      .clock, .srst, .direction, .host_dma_enable, .scsi_dma_enable,
      .buffer_pointer_reset, .low_host_address, .host_byte_count,
      .wr_pointer_load, .wr_pointer, .rd_pointer_load, .rd_pointer,
      .seq_wr, .seq_wdata, .seq_rd, .host_wr, .host_wdata, .host_rd,
      .scsi_wr, .scsi_wdata, .scsi_rd, .diag_clear, .rd_data, .rd_valid,
      .fifo_wr_quad_ptr, .fifo_rd_quad_ptr, .wr_byte_offset,
      .rd_byte_offset, .read_port, .write_port, .host_transfer_done,
      .diag_break_interrupt, .pci_byte_offset, .host_block_offset,
      .scsi_block_offset
   );

   dma_peer dma_peer_inst (
      .clock, .run(peer_run), .to_fifo(peer_to_fifo), .slow(peer_slow),
      .n_bytes(peer_n), .busy(peer_busy), .host_wr, .host_rd, .host_wdata
   );

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // read bytes are collected here, so back-to-back reads need no timing
   always @(posedge clock) begin
      if (rd_valid === 1'b1) begin
         rdq.push_back(rd_data);
      end
   end

   // ==========================================================
   // shared tasks
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask

   function automatic logic [7:0] wpos();
      return {fifo_wr_quad_ptr, wr_byte_offset};
   endfunction

   function automatic logic [7:0] rpos();
      return {fifo_rd_quad_ptr, rd_byte_offset};
   endfunction

   task automatic chk_q(input logic [7:0] first, input int n);
      chk("read count", rdq.size(), n);
      for (int i = 0; i < n; i++) begin
         chk("read byte", rdq[i], first + i[7:0]);
      end
      rdq.delete();
   endtask

   task automatic set_flow(input logic [2:0] f);
      {direction, host_dma_enable, scsi_dma_enable} = f;
      tick(2);
   endtask

   task automatic ptr_reset(input logic [2:0] a, input logic [23:0] cnt);
      low_host_address = a;
      host_byte_count = cnt;
      buffer_pointer_reset = 1'b1;
      tick(1);
      buffer_pointer_reset = 1'b0;
      tick(2);
   endtask

   task automatic seq_fill(input logic [7:0] first, input int n);
      for (int i = 0; i < n; i++) begin
         seq_wdata = first + i[7:0];
         seq_wr = 1'b1;
         tick(1);
      end
      seq_wr = 1'b0;
      tick(2);
   endtask

   task automatic seq_drain(input int n);
      seq_rd = 1'b1;
      tick(n);
      seq_rd = 1'b0;
      tick(4);
   endtask

   task automatic peer(input logic to_f, input logic sl, input int n);
      int k;
      k = 0;
      peer_to_fifo = to_f;
      peer_slow = sl;
      peer_n = n[7:0];
      peer_run = 1'b1;
      tick(2);
      peer_run = 1'b0;
      while (peer_busy && k < 40) begin
         k++;
         tick(1);
      end
      chk("peer finished", peer_busy, 1'b0);
      tick(3);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_flow;
      logic [2:0]           fc [8];
      dfifo_pkg::port_sel_t er [8];
      dfifo_pkg::port_sel_t ew [8];
      fc = '{3'h3, 3'h1, 3'h2, 3'h0, 3'h4, 3'h7, 3'h5, 3'h6};
      er = '{HO, SQ, HO, SQ, SQ, SC, SC, SQ};
      ew = '{SC, SC, SQ, SQ, SQ, HO, SQ, HO};
      for (int i = 0; i < 8; i++) begin
         set_flow(fc[i]);
         chk("read port", read_port, er[i]);
         chk("write port", write_port, ew[i]);
      end
   endtask

   task automatic t_seq;
      set_flow(3'h0);
      ptr_reset(3'h5, 24'h000000);
      seq_fill(8'h10, 6);
      chk("wr position", wpos(), 8'h0b);
      chk("rd position", rpos(), 8'h05);
      seq_drain(6);
      chk("rd position", rpos(), 8'h0b);
      chk_q(8'h10, 6);
      wr_pointer = 5'h07;
      rd_pointer = 5'h07;
      {wr_pointer_load, rd_pointer_load} = 2'h3;
      tick(1);
      {wr_pointer_load, rd_pointer_load} = 2'h0;
      tick(2);
      chk("wr reload", wpos(), 8'h3b);
      chk("rd reload", rpos(), 8'h3b);
      seq_fill(8'h40, 3);
      chk("wr after reload", wpos(), 8'h3e);
      seq_drain(3);
      chk_q(8'h40, 3);
   endtask

   task automatic t_offsets;
      logic [2:0] a;
      for (int i = 0; i < 8; i++) begin
         a = i[2:0];
         set_flow(3'h3);
         ptr_reset(a, 24'h000000);
         chk("scsi offset", wr_byte_offset, {a[2:1], 1'b0});
         chk("host offset", rd_byte_offset, 3'h0);
         chk("pci offset", pci_byte_offset, a[1:0]);
         chk("host block", host_block_offset, a[2] ? 3'h4 : 3'h0);
         chk("scsi block", scsi_block_offset, a[0]);
         set_flow(3'h0);
         ptr_reset(a, 24'h000000);
         chk("seq wr offset", wr_byte_offset, a);
         chk("seq rd offset", rd_byte_offset, a);
         chk("quads", {fifo_wr_quad_ptr, fifo_rd_quad_ptr}, 10'h0);
      end
   endtask

   task automatic t_clash;
      logic [7:0] w;
      logic [7:0] r;
      set_flow(3'h0);
      w = wpos();
      scsi_wdata = 8'hee;
      scsi_wr = 1'b1;
      tick(1);
      scsi_wr = 1'b0;
      tick(2);
      chk("clash flag", diag_break_interrupt, 1'b1);
      chk("refused write", wpos(), w);
      diag_clear = 1'b1;
      tick(1);
      diag_clear = 1'b0;
      tick(2);
      chk("clash cleared", diag_break_interrupt, 1'b0);
      set_flow(3'h1);
      {scsi_wr, seq_wr} = 2'h3;
      tick(1);
      {scsi_wr, seq_wr} = 2'h0;
      tick(2);
      chk("two writers", diag_break_interrupt, 1'b1);
      chk("two writers", wpos(), w);
      diag_clear = 1'b1;
      scsi_wr = 1'b1;
      r = rpos();
      tick(1);
      {diag_clear, scsi_wr, scsi_rd} = 3'h1;
      tick(1);
      scsi_rd = 1'b0;
      tick(3);
      chk("scsi write", wpos(), w + 8'h01);
      chk("scsi read", rpos(), r + 8'h01);
      chk("no clash", diag_break_interrupt, 1'b0);
      rdq.delete();
   endtask

   task automatic t_dma_out;
      set_flow(3'h0);
      ptr_reset(3'h0, 24'h000004);
      seq_fill(8'h60, 4);
      chk("done early", host_transfer_done, 1'b0);
      set_flow(3'h2);
      peer(1'b0, 1'b1, 4);
      chk("done out", host_transfer_done, 1'b1);
      chk_q(8'h60, 4);
   endtask

   task automatic t_dma_in;
      set_flow(3'h6);
      ptr_reset(3'h0, 24'h000005);
      chk("done cleared", host_transfer_done, 1'b0);
      peer(1'b1, 1'b0, 5);
      chk("done in", host_transfer_done, 1'b1);
      rdq.delete();
      seq_drain(5);
      chk_q(8'ha0, 5);
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      srst = 1'b1;
      {direction, host_dma_enable, scsi_dma_enable, buffer_pointer_reset,
       wr_pointer_load, rd_pointer_load, seq_wr, seq_rd, scsi_wr, scsi_rd,
       diag_clear, peer_run, peer_to_fifo, peer_slow} = '0;
      {low_host_address, wr_pointer, rd_pointer, seq_wdata, scsi_wdata,
       peer_n, host_byte_count} = '0;
      tick(2);
      srst = 1'b0;
      t_flow();
      t_seq();
      t_offsets();
      t_clash();
      t_dma_out();
      t_dma_in();
      stop_test();
   end

   // whole run is a few hundred cycles; this bound only cuts a hang
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      stop_test();
   end
endmodule
